// *** acc_pkg.sv ***
// Constants shared by the analog comparator control block.
// Assumes a 32-bit AHB-Lite bus and 10-bit analog level codes.
package acc_pkg;

  // ==========================================================
  // Register indices and address width
  // ==========================================================
  localparam logic [7:0]  ACC_IDX_CTRL_STATUS = 8'h50;
  localparam logic [7:0]  ACC_IDX_CONV_CTRL_B = 8'h7B;
  localparam logic [7:0]  ACC_IDX_BUF_DISABLE = 8'h7F;
  localparam logic [7:0]  ACC_IDX_IRQ_STATUS  = 8'h80;
  localparam logic [7:0]  ACC_IDX_IRQ_MASK    = 8'h81;
  localparam int          ACC_ADDR_W          = 10;

  // ==========================================================
  // Comparator control/status field positions
  // ==========================================================
  localparam int ACC_CS_DISABLE   = 7;
  localparam int ACC_CS_BANDGAP   = 6;
  localparam int ACC_CS_RESULT    = 5;
  localparam int ACC_CS_FLAG      = 4;
  localparam int ACC_CS_IRQ_EN    = 3;
  localparam int ACC_CS_ROUTE     = 2;
  localparam int ACC_CS_EDGE_HI   = 1;
  localparam int ACC_CS_EDGE_LO   = 0;

  // Converter control B and buffer disable fields
  localparam int ACC_CB_MUX_NEG   = 6;
  localparam int ACC_CB_TRIG_HI   = 2;
  localparam int ACC_BD_NEG       = 1;
  localparam int ACC_BD_POS       = 0;
  localparam logic [7:0] ACC_CB_WMASK = 8'h47;

  // Interrupt status/mask layout
  localparam int ACC_IS_EVENT     = 0;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] ACC_RST_CTRL = 8'h00;
  localparam logic [7:0] ACC_RST_CB   = 8'h00;
  localparam logic [1:0] ACC_RST_BD   = 2'h0;

  // ==========================================================
  // Analog level model
  // ==========================================================
  localparam int          ACC_LVL_W    = 10;
  localparam logic [9:0]  ACC_BANDGAP  = 10'h119;

  // Edge modes of the interrupt event select
  typedef enum logic [1:0] {
    ACC_EDGE_TOGGLE  = 2'h0,
    ACC_EDGE_RSVD    = 2'h1,
    ACC_EDGE_FALL    = 2'h2,
    ACC_EDGE_RISE    = 2'h3
  } acc_edge_t;

  // AHB transfer type bit that marks an active transfer
  localparam int ACC_HTRANS_ACT = 1;

endpackage

// *** acc_sync.sv ***
// Two-stage synchroniser with a hold input.
// Assumes d may change at any time relative to clk.
`timescale 1ns/100ps
module acc_sync (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic hold,
  input  wire logic d,
  output logic      q
);
  import acc_pkg::*;

  logic stage1_ff;
  logic stage2_ff;

  // ==========================================================
  // First stage feeds only the second stage
  // ==========================================================
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_ff <= 1'b0;
    end else begin
      stage1_ff <= d;
    end
  end

  // Second stage freezes while hold is high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage2_ff <= 1'b0;
    end else if (!hold) begin
      stage2_ff <= stage1_ff;
    end
  end

  assign q = stage2_ff;

endmodule

// *** acc_top.sv ***
// Analog comparator control: input selection, result synchroniser,
// edge events, flag, interrupts, capture routing, buffer disables.
// Assumes one 10 MHz clock, an AHB-Lite master, and analog levels
// given as codes that change slowly against the clock.
`timescale 1ns/100ps
module acc_top (
  input  wire logic                    CLK,
  input  wire logic                    ARST_N,
  input  wire logic                    HSEL,
  input  wire logic [31:0]             HADDR,
  input  wire logic [1:0]              HTRANS,
  input  wire logic                    HWRITE,
  input  wire logic [2:0]              HSIZE,
  input  wire logic [31:0]             HWDATA,
  input  wire logic                    HREADY,
  output logic      [31:0]             HRDATA,
  output logic                         HREADYOUT,
  output logic                         HRESP,
  input  wire logic [acc_pkg::ACC_LVL_W-1:0] POS_PIN_LEVEL,
  input  wire logic [acc_pkg::ACC_LVL_W-1:0] NEG_PIN_LEVEL,
  input  wire logic [7:0][acc_pkg::ACC_LVL_W-1:0] CHANNEL_LEVEL,
  input  wire logic                    CONVERTER_ENABLE,
  input  wire logic [2:0]              CHANNEL_SELECT,
  input  wire logic                    GLOBAL_IRQ_ENABLE,
  input  wire logic                    VECTOR_SERVICED,
  input  wire logic                    POS_PIN_DIGITAL,
  input  wire logic                    NEG_PIN_DIGITAL,
  output logic                         POS_PIN_READ,
  output logic                         NEG_PIN_READ,
  output logic                         COMPARATOR_POWER,
  output logic                         CAPTURE_OUT,
  output logic                         CMP_IRQ_REQ,
  output logic                         IRQ,
  output logic [2:0]                   TRIGGER_SOURCE_SELECT
);
  import acc_pkg::*;

  logic [7:0]           ctrl_ff;
  logic [7:0]           convb_ff;
  logic [1:0]           bufdis_ff;
  logic                 flag_ff;
  logic                 irq_stat_ff;
  logic                 irq_mask_ff;
  logic                 prev_ff;
  logic [1:0]           pin_s1_ff;
  logic [1:0]           pin_s2_ff;
  logic                 wr_pend_ff;
  logic [7:0]           wr_idx_ff;
  logic [31:0]          rdata_ff;
  logic                 nxt_flag;
  logic                 nxt_irq_stat;
  logic [ACC_LVL_W-1:0] pos_level;
  logic [ACC_LVL_W-1:0] neg_level;
  logic                 raw_cmp;
  logic                 result;
  logic                 edge_evt;
  logic                 addr_ok;
  logic                 accept;
  logic [7:0]           acc_idx;
  logic [31:0]          rd_mux;
  logic                 wr_cs;
  logic                 flag_w1c;
  logic                 stat_w1c;
  acc_edge_t            edge_mode;
  logic                 comp_off;
  logic                 mux_borrow;

  // ==========================================================
  // Input selection and comparison
  // ==========================================================
  // Converter running means its multiplexer is not ours to use
  assign mux_borrow = convb_ff[ACC_CB_MUX_NEG] & ~CONVERTER_ENABLE;

  // Negative input: channel pin or dedicated pin
  always_comb begin
    neg_level = NEG_PIN_LEVEL;
    if (mux_borrow) begin
      neg_level = CHANNEL_LEVEL[CHANNEL_SELECT];
    end
  end

  // Positive input: bandgap or dedicated pin
  assign pos_level = ctrl_ff[ACC_CS_BANDGAP] ? ACC_BANDGAP
                                             : POS_PIN_LEVEL;

  // Analog comparison model; ties count as not above
  assign raw_cmp  = (pos_level > neg_level);
  assign comp_off = ctrl_ff[ACC_CS_DISABLE];
  assign COMPARATOR_POWER = ~comp_off;

  // ==========================================================
  // Result synchroniser and edge detection
  // ==========================================================
  // Level codes are asynchronous; only the one-bit result crosses
  acc_sync u_result_sync (
    .clk    (CLK),
    .arst_n (ARST_N),
    .hold   (comp_off),
    .d      (raw_cmp),
    .q      (result)
  );

  // Previous result for edge compare
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= result;
    end
  end

  assign edge_mode = acc_edge_t'(ctrl_ff[ACC_CS_EDGE_HI:ACC_CS_EDGE_LO]);

  // Event decode; reserved mode is deliberately dead
  always_comb begin
    case (edge_mode)
      ACC_EDGE_TOGGLE: edge_evt = result ^ prev_ff;
      ACC_EDGE_FALL:   edge_evt = prev_ff & ~result;
      ACC_EDGE_RISE:   edge_evt = result & ~prev_ff;
      ACC_EDGE_RSVD:   edge_evt = 1'b0;
      default:         edge_evt = 1'b0;
    endcase
  end

  // Capture route is a plain gate, so timer filtering stays in timer
  assign CAPTURE_OUT = ctrl_ff[ACC_CS_ROUTE] & result;

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  // ==========================================================
  assign acc_idx   = HADDR[9:2];
  assign addr_ok   = (HADDR[1:0] == 2'h0) && (HADDR[31:ACC_ADDR_W] == '0);
  assign accept    = HSEL & HTRANS[ACC_HTRANS_ACT] & HREADY;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata_ff;

  // Read mux; unmapped and reserved bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_ok) begin
      case (acc_idx)
        ACC_IDX_CTRL_STATUS: begin
          rd_mux[7:0] = ctrl_ff;
          rd_mux[ACC_CS_RESULT] = result;
          rd_mux[ACC_CS_FLAG]   = flag_ff;
        end
        ACC_IDX_CONV_CTRL_B: rd_mux[7:0] = convb_ff & ACC_CB_WMASK;
        ACC_IDX_BUF_DISABLE: rd_mux[1:0] = bufdis_ff;
        ACC_IDX_IRQ_STATUS:  rd_mux[ACC_IS_EVENT] = irq_stat_ff;
        ACC_IDX_IRQ_MASK:    rd_mux[ACC_IS_EVENT] = irq_mask_ff;
        default:             rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Address phase capture; read data sampled at address phase
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 8'h00;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      if (HREADY) begin
        wr_pend_ff <= accept & HWRITE & addr_ok;
        wr_idx_ff  <= acc_idx;
      end
      if (accept && !HWRITE) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  assign wr_cs = wr_pend_ff && (wr_idx_ff == ACC_IDX_CTRL_STATUS);

  // ==========================================================
  // Control registers
  // ==========================================================
  // Result and flag bits are not stored through the write path
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_ff <= ACC_RST_CTRL;
    end else if (wr_cs) begin
      ctrl_ff[ACC_CS_DISABLE] <= HWDATA[ACC_CS_DISABLE];
      ctrl_ff[ACC_CS_BANDGAP] <= HWDATA[ACC_CS_BANDGAP];
      ctrl_ff[ACC_CS_IRQ_EN]  <= HWDATA[ACC_CS_IRQ_EN];
      ctrl_ff[ACC_CS_ROUTE]   <= HWDATA[ACC_CS_ROUTE];
      ctrl_ff[ACC_CS_EDGE_HI:ACC_CS_EDGE_LO] <=
        HWDATA[ACC_CS_EDGE_HI:ACC_CS_EDGE_LO];
    end
  end

  // Converter control B keeps only its writable bits
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      convb_ff <= ACC_RST_CB;
    end else if (wr_pend_ff && (wr_idx_ff == ACC_IDX_CONV_CTRL_B)) begin
      convb_ff <= HWDATA[7:0] & ACC_CB_WMASK;
    end
  end

  assign TRIGGER_SOURCE_SELECT = convb_ff[ACC_CB_TRIG_HI:0];

  // Buffer disable bits
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bufdis_ff <= ACC_RST_BD;
    end else if (wr_pend_ff && (wr_idx_ff == ACC_IDX_BUF_DISABLE)) begin
      bufdis_ff <= HWDATA[1:0];
    end
  end

  // ==========================================================
  // Comparator flag and request
  // ==========================================================
  assign flag_w1c = wr_cs & HWDATA[ACC_CS_FLAG];

  // Event wins over a same-cycle clear so no edge is lost
  always_comb begin
    nxt_flag = flag_ff;
    if (flag_w1c || VECTOR_SERVICED) begin
      nxt_flag = 1'b0;
    end
    if (edge_evt) begin
      nxt_flag = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign CMP_IRQ_REQ = flag_ff & ctrl_ff[ACC_CS_IRQ_EN]
                     & GLOBAL_IRQ_ENABLE;

  // ==========================================================
  // Sticky interrupt status and mask
  // ==========================================================
  assign stat_w1c = wr_pend_ff && (wr_idx_ff == ACC_IDX_IRQ_STATUS)
                 && HWDATA[ACC_IS_EVENT];

  // Same set-over-clear order as the flag
  always_comb begin
    nxt_irq_stat = irq_stat_ff & ~stat_w1c;
    if (edge_evt) begin
      nxt_irq_stat = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_stat_ff <= 1'b0;
      irq_mask_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      if (wr_pend_ff && (wr_idx_ff == ACC_IDX_IRQ_MASK)) begin
        irq_mask_ff <= HWDATA[ACC_IS_EVENT];
      end
    end
  end

  assign IRQ = irq_stat_ff & irq_mask_ff;

  // ==========================================================
  // Pin digital input buffers
  // ==========================================================
  // Pins are asynchronous; two stages before the gating
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_s1_ff <= 2'h0;
      pin_s2_ff <= 2'h0;
    end else begin
      pin_s1_ff <= {NEG_PIN_DIGITAL, POS_PIN_DIGITAL};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  assign NEG_PIN_READ = pin_s2_ff[1] & ~bufdis_ff[ACC_BD_NEG];
  assign POS_PIN_READ = pin_s2_ff[0] & ~bufdis_ff[ACC_BD_POS];

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sync_latency_a: assert property (
    (!comp_off)[*3] |-> result == $past(raw_cmp, 2))
    else $error("result does not follow raw compare by two cycles");

  hold_disabled_a: assert property (
    comp_off && $past(comp_off) |-> $stable(result))
    else $error("result moved while comparator disabled");

  flag_set_a: assert property (
    edge_evt |=> flag_ff)
    else $error("edge event did not set flag");

  reserved_mode_a: assert property (
    edge_mode == ACC_EDGE_RSVD && !flag_ff |=> !flag_ff)
    else $error("reserved mode set the flag");

  rise_edge_a: assert property (
    edge_mode == ACC_EDGE_RISE && !flag_ff && $fell(result)
    |=> !flag_ff)
    else $error("falling edge flagged in rising mode");

  ack_clear_a: assert property (
    VECTOR_SERVICED && !edge_evt |=> !flag_ff)
    else $error("flag not cleared by vector service");

  irq_gate_a: assert property (
    CMP_IRQ_REQ |-> flag_ff && ctrl_ff[ACC_CS_IRQ_EN] && GLOBAL_IRQ_ENABLE)
    else $error("request without flag and both enables");

  capture_off_a: assert property (
    !ctrl_ff[ACC_CS_ROUTE] |-> !CAPTURE_OUT)
    else $error("capture driven while route disabled");

  neg_select_a: assert property (
    mux_borrow |-> neg_level == CHANNEL_LEVEL[CHANNEL_SELECT])
    else $error("negative input not taken from channel");

  conv_block_a: assert property (
    CONVERTER_ENABLE |-> neg_level == NEG_PIN_LEVEL)
    else $error("channel borrowed while converter enabled");

  buffer_off_a: assert property (
    bufdis_ff[ACC_BD_NEG] |-> !NEG_PIN_READ)
    else $error("disabled negative buffer reads one");

  convb_read_a: assert property (
    accept && !HWRITE && acc_idx == ACC_IDX_CONV_CTRL_B
    |=> (HRDATA & ~{24'h00_0000, ACC_CB_WMASK}) == 32'h0000_0000)
    else $error("converter control B reserved bits read nonzero");

  power_off_a: assert property (
    wr_cs && HWDATA[ACC_CS_DISABLE] |=> !COMPARATOR_POWER)
    else $error("disable write did not power comparator off");

endmodule

// *** acc_far.sv ***
// Far side model: analog levels, pin digital levels, capture timer.
// Assumes set_lv and set_ch are called just after a rising edge.
`timescale 1ns/100ps
module acc_far (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       cap_in,
  output logic [9:0]      pos_lv,
  output logic [9:0]      neg_lv,
  output logic [7:0][9:0] ch_lv,
  output logic            pos_dig,
  output logic            neg_dig,
  output logic [7:0]      cap_cnt
);
  logic cap_q;
  // ==========================================
  // Analog sources
  // ==========================================
  initial begin
    pos_lv = 10'h100;
    neg_lv = 10'h200;
    ch_lv  = '0;
  end
  task automatic set_lv(input logic [9:0] p, input logic [9:0] n);
    pos_lv <= p;
    neg_lv <= n;
  endtask
  // Only the chosen channel is high, so a wrong pick flips the result
  task automatic set_ch(input logic [2:0] s);
    for (int i = 0; i < 8; i++) begin
      ch_lv[i] <= (3'(i) == s) ? 10'h300 : 10'h000;
    end
  endtask
  // Pin buffers read the upper half of the scale as one
  assign pos_dig = pos_lv[9];
  assign neg_dig = neg_lv[9];
  // ==========================================
  // Timer capture: rising edges, no noise filter modelled
  // ==========================================
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_q   <= 1'b0;
      cap_cnt <= 8'h00;
    end else begin
      cap_q <= cap_in;
      if (cap_in && !cap_q) begin
        cap_cnt <= cap_cnt + 8'h01;
      end
    end
  end
endmodule

// *** tb_top.sv ***
// Self-checking bench for the comparator control block.
// Assumes a zero-wait AHB-Lite slave and the far side model.
`timescale 1ns/100ps
module tb_top;
  import acc_pkg::*;
  localparam logic [31:0] CS = {22'h0, ACC_IDX_CTRL_STATUS, 2'h0};
  localparam logic [31:0] CB = {22'h0, ACC_IDX_CONV_CTRL_B, 2'h0};
  localparam logic [31:0] BD = {22'h0, ACC_IDX_BUF_DISABLE, 2'h0};
  localparam logic [31:0] IS = {22'h0, ACC_IDX_IRQ_STATUS, 2'h0};
  localparam logic [31:0] IM = {22'h0, ACC_IDX_IRQ_MASK, 2'h0};
  logic             CLK, ARST_N, HWRITE, HREADYOUT, HRESP;
  logic [1:0]       HTRANS;
  logic [31:0]      HADDR, HWDATA, HRDATA;
  logic [9:0]       POS_LV, NEG_LV;
  logic [7:0][9:0]  CH_LV;
  logic             CONVERTER_ENABLE, GLOBAL_IRQ_ENABLE, VECTOR_SERVICED;
  logic [2:0]       CHANNEL_SELECT, TRIGGER_SOURCE_SELECT;
  logic             POS_DIG, NEG_DIG, POS_PIN_READ, NEG_PIN_READ;
  logic             COMPARATOR_POWER, CAPTURE_OUT, CMP_IRQ_REQ, IRQ;
  logic [7:0]       cap_cnt;
  int               bad_count, checked;
  acc_top uut (.CLK(CLK), .ARST_N(ARST_N), .HSEL(1'b1), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .POS_PIN_LEVEL(POS_LV), .NEG_PIN_LEVEL(NEG_LV),
    .CHANNEL_LEVEL(CH_LV), .CONVERTER_ENABLE(CONVERTER_ENABLE),
    .CHANNEL_SELECT(CHANNEL_SELECT), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
    .VECTOR_SERVICED(VECTOR_SERVICED), .POS_PIN_DIGITAL(POS_DIG),
    .NEG_PIN_DIGITAL(NEG_DIG), .POS_PIN_READ(POS_PIN_READ),
    .NEG_PIN_READ(NEG_PIN_READ), .COMPARATOR_POWER(COMPARATOR_POWER),
    .CAPTURE_OUT(CAPTURE_OUT), .CMP_IRQ_REQ(CMP_IRQ_REQ), .IRQ(IRQ),
    .TRIGGER_SOURCE_SELECT(TRIGGER_SOURCE_SELECT));
  acc_far far (.clk(CLK), .arst_n(ARST_N), .cap_in(CAPTURE_OUT),
    .pos_lv(POS_LV), .neg_lv(NEG_LV), .ch_lv(CH_LV), .pos_dig(POS_DIG),
    .neg_dig(NEG_DIG), .cap_cnt(cap_cnt));
  // ==========================================
  // Clock and common tasks
  // ==========================================
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Single word transfer; waits on ready, never on a fixed count
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    HTRANS <= 2'h2;
    HADDR  <= a;
    HWRITE <= w;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    r = HRDATA;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic test_done;
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_reset;
    rd(CS, 32'h0);
    rd(CB, 32'h0);
    rd(BD, 32'h0);
    rd(IS, 32'h0);
    rd(IM, 32'h0);
    chk(COMPARATOR_POWER, 32'h1);
    chk(HRESP, 32'h0);
    chk(HREADYOUT, 32'h1);
    wr(CB, 32'hFF);
    rd(CB, 32'h47);
    chk(TRIGGER_SOURCE_SELECT, 32'h7);
    wr(CB, 32'h0);
    wr(32'h300, 32'hFF);
    rd(32'h300, 32'h0);
  endtask
  // Each mode sees one rise and one fall; interrupt enable stays off
  task automatic t_edges;
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      wr(CS, {27'h0, 1'b1, 2'h0, m});
      far.set_lv(10'h300, 10'h200);
      tick(4);
      rd(CS, {26'h0, 1'b1, m == 2'h0 || m == 2'h3, 2'h0, m});
      wr(CS, {27'h0, 1'b1, 2'h0, m});
      far.set_lv(10'h100, 10'h200);
      tick(4);
      rd(CS, {27'h0, m == 2'h0 || m == 2'h2, 2'h0, m});
    end
  endtask
  task automatic t_irq;
    // Earlier scenarios left the sticky status set; start from clear
    wr(IS, 32'h1);
    wr(IM, 32'h1);
    wr(CS, 32'h1B);
    far.set_lv(10'h300, 10'h200);
    tick(4);
    chk(CMP_IRQ_REQ, 32'h0);
    chk(IRQ, 32'h1);
    GLOBAL_IRQ_ENABLE <= 1'b1;
    tick(2);
    chk(CMP_IRQ_REQ, 32'h1);
    wr(CS, 32'h0B);
    tick(1);
    chk(CMP_IRQ_REQ, 32'h1);
    VECTOR_SERVICED <= 1'b1;
    tick(1);
    VECTOR_SERVICED <= 1'b0;
    tick(1);
    chk(CMP_IRQ_REQ, 32'h0);
    rd(CS, 32'h2B);
    wr(IS, 32'h1);
    tick(1);
    chk(IRQ, 32'h0);
    far.set_lv(10'h100, 10'h200);
    tick(4);
    far.set_lv(10'h300, 10'h200);
    tick(4);
    chk(CMP_IRQ_REQ, 32'h1);
    wr(CS, 32'h03);
    tick(1);
    chk(CMP_IRQ_REQ, 32'h0);
    rd(CS, 32'h33);
    wr(CS, 32'h13);
    rd(CS, 32'h23);
    GLOBAL_IRQ_ENABLE <= 1'b0;
    wr(IS, 32'h1);
    wr(IM, 32'h0);
  endtask
  // Reserved edge mode keeps the flag out of the way here
  task automatic t_mux;
    wr(CS, 32'h11);
    wr(CB, 32'h40);
    far.set_lv(10'h200, 10'h100);
    for (int s = 0; s < 8; s++) begin
      CHANNEL_SELECT <= 3'(s);
      far.set_ch(3'(s));
      tick(4);
      rd(CS, 32'h01);
    end
    CONVERTER_ENABLE <= 1'b1;
    tick(4);
    rd(CS, 32'h21);
    CONVERTER_ENABLE <= 1'b0;
    wr(CB, 32'h0);
    tick(3);
    rd(CS, 32'h21);
  endtask
  task automatic t_bg;
    wr(CS, 32'h41);
    far.set_lv(10'h000, 10'h118);
    tick(4);
    rd(CS, 32'h61);
    far.set_lv(10'h000, 10'h119);
    tick(4);
    rd(CS, 32'h41);
    wr(CS, 32'h01);
    far.set_lv(10'h200, 10'h200);
    tick(4);
    rd(CS, 32'h01);
  endtask
  // Toggle mode while off: any event would show up in the flag
  task automatic t_dis;
    wr(CS, 32'h90);
    tick(1);
    chk(COMPARATOR_POWER, 32'h0);
    far.set_lv(10'h300, 10'h200);
    tick(4);
    rd(CS, 32'h80);
    wr(CS, 32'h01);
    tick(1);
    chk(COMPARATOR_POWER, 32'h1);
    tick(3);
    rd(CS, 32'h21);
  endtask
  task automatic t_route;
    logic [7:0] c;
    wr(CS, 32'h05);
    tick(1);
    chk(CAPTURE_OUT, 32'h1);
    far.set_lv(10'h100, 10'h200);
    tick(4);
    chk(CAPTURE_OUT, 32'h0);
    // Enabling the route already gave one rising edge; count from here
    c = cap_cnt;
    far.set_lv(10'h300, 10'h200);
    tick(4);
    chk(cap_cnt, c + 8'h01);
    wr(CS, 32'h01);
    tick(1);
    chk(CAPTURE_OUT, 32'h0);
  endtask
  task automatic t_pins;
    tick(3);
    chk({POS_PIN_READ, NEG_PIN_READ}, 32'h3);
    wr(BD, 32'h1);
    tick(3);
    chk({POS_PIN_READ, NEG_PIN_READ}, 32'h1);
    wr(BD, 32'hFF);
    tick(3);
    chk({POS_PIN_READ, NEG_PIN_READ}, 32'h0);
    rd(BD, 32'h3);
    wr(BD, 32'h2);
    tick(3);
    chk({POS_PIN_READ, NEG_PIN_READ}, 32'h2);
  endtask
  // ==========================================
  // Main sequence and watchdog
  // ==========================================
  initial begin
    ARST_N = 1'b0;
    HTRANS = 2'h0;
    HADDR = 32'h0;
    HWRITE = 1'b0;
    HWDATA = 32'h0;
    CONVERTER_ENABLE = 1'b0;
    CHANNEL_SELECT = 3'h0;
    GLOBAL_IRQ_ENABLE = 1'b0;
    VECTOR_SERVICED = 1'b0;
    bad_count = 0;
    checked = 0;
    tick(16);
    ARST_N <= 1'b1;
    tick(1);
    t_reset();
    t_edges();
    t_irq();
    t_mux();
    t_bg();
    t_dis();
    t_route();
    t_pins();
    test_done();
  end
  // Run needs well under a thousand cycles; 20000 means a hang
  initial begin
    #2000000;
    bad_count++;
    test_done();
  end
endmodule
